//--- bae_consts.vh
// Constants for the beam area evaluator: addresses, record layout, codes and defaults
`ifndef BAE_CONSTS_VH
`define BAE_CONSTS_VH

// Word indices; byte address is four times the index
`define BAE_IDX_STG0 10'h000
`define BAE_IDX_STG1 10'h001
`define BAE_IDX_STG2 10'h002
`define BAE_IDX_STG3 10'h003
`define BAE_IDX_RESULT 10'h004
`define BAE_IDX_STATUS 10'h005
`define BAE_IDX_REFA 10'h006
`define BAE_IDX_REFB 10'h007
`define BAE_AREA_FIRST_IDX 10'h064
`define BAE_AREA_LAST_IDX 10'h083

// Record layout
`define BAE_CFG_W 112
`define BAE_F8_W 8
`define BAE_F16_W 16
`define BAE_EN_LSB 104
`define BAE_POL_LSB 96
`define BAE_START_LSB 80
`define BAE_END_LSB 64
`define BAE_ON_LSB 48
`define BAE_OFF_LSB 32
`define BAE_MID_LSB 16
`define BAE_WID_LSB 0
`define BAE_STG_W 32
`define BAE_STG3_W 16

// Record reset value: start and end at beam 1, rest zero
`define BAE_CFG_DEFAULT 112'h0000_0001_0001_0000_0000_0000_0000
`define BAE_EN_ON 8'h01
`define BAE_POL_LIGHT 8'h00

// Symbolic boundary codes
`define BAE_CODE_FB 16'hfffe
`define BAE_CODE_FC 16'hfffd
`define BAE_CODE_LB 16'hfffc
`define BAE_CODE_LC 16'hfffb
`define BAE_CODE_TM 16'hfffa

// Sizes
`define BAE_AREA_AW 5
`define BAE_BEAM_AW 11
`define BAE_LAST_AREA 5'h1f
`define BAE_MAX_BEAMS 11'h6ee
`define BAE_BEAM_ONE 11'h001
`define BAE_BEAM_ONE16 16'h0001
`define BAE_ZERO16 16'h0000

`endif

//--- bae_mem.v
// Single-port memory with registered read data
`timescale 1ns/1ps
module bae_mem #(
	parameter W = 8,
	parameter AW = 4
) (
	input wire clk, // Clock
	input wire ce, // Clock enable, freezes the memory when low
	input wire we, // Write strobe
	input wire [AW-1:0] addr, // Word address
	input wire [W-1:0] wdata, // Write data
	output reg [W-1:0] rdata_q // Read data, one cycle after the address
);

	reg [W-1:0] mem [0:(1<<AW)-1];

	// Write and registered read; a read in a write cycle sees old contents
	always @(posedge clk)
	begin
		if (ce)
		begin
			if (we)
				mem[addr] <= wdata;
			rdata_q <= mem[addr];
		end
	end

endmodule

//--- bae_top.v
// Beam area evaluator: area record store, APB slave, scan capture and area evaluation
`timescale 1ns/1ps
`include "bae_consts.vh"
module bae_top (
	input wire pclk, // APB clock, 25 MHz
	input wire presetn, // Asynchronous reset, active low
	input wire ce, // Clock enable, freezes all state when low
	input wire [11:0] paddr, // APB byte address
	input wire psel, // APB select
	input wire penable, // APB access phase
	input wire pwrite, // APB direction, high for write
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error on unmapped address
	input wire scan_start, // Level: held high for the whole scan, its fall starts the evaluation
	input wire beam_valid, // Pulse: one beam state in logical order
	input wire beam_blocked, // Beam light path interrupted
	input wire [15:0] target_minimum_beam, // Target minimum beam from the scan front end
	output reg [31:0] area_result, // Evaluation result of areas 1 to 32
	output reg eval_done // Pulse: all areas evaluated for this scan
);

	localparam S_IDLE = 3'h0;
	localparam S_SCAN = 3'h1;
	localparam S_CFG = 3'h2;
	localparam S_RES = 3'h3;
	localparam S_PE = 3'h4;
	localparam S_PS = 3'h5;
	localparam S_CNT = 3'h6;

	reg [2:0] state_q;
	reg [`BAE_AREA_AW-1:0] area_q;
	reg [`BAE_BEAM_AW-1:0] beam_cnt_q;
	reg [`BAE_BEAM_AW-1:0] blk_cnt_q;
	reg [15:0] first_blocked_beam_q;
	reg [15:0] first_clear_beam_q;
	reg [15:0] last_blocked_beam_q;
	reg [15:0] last_clear_beam_q;
	reg [15:0] tmin_q;
	reg [15:0] s_q;
	reg [15:0] e_q;
	reg [7:0] en_q;
	reg [7:0] pol_q;
	reg [15:0] on_q;
	reg [15:0] off_q;
	reg [`BAE_BEAM_AW-1:0] pe_q;
	reg [31:0] area_init_q;
	reg apb_mem_q;
	reg [`BAE_STG_W-1:0] stg0_q;
	reg [`BAE_STG_W-1:0] stg1_q;
	reg [`BAE_STG_W-1:0] stg2_q;
	reg [`BAE_STG3_W-1:0] stg3_q;

	wire [9:0] widx;
	wire [9:0] area_off;
	wire area_hit;
	wire access;
	wire apb_cfg_go;
	wire [`BAE_AREA_AW-1:0] cfg_addr;
	wire [`BAE_CFG_W-1:0] cfg_rd;
	wire [`BAE_CFG_W-1:0] cfg_rec;
	wire [`BAE_CFG_W-1:0] cfg_wdata;
	wire cfg_we;
	wire [`BAE_BEAM_AW-1:0] beam_next;
	wire [`BAE_BEAM_AW-1:0] pfx_addr;
	wire [`BAE_BEAM_AW-1:0] pfx_rd;
	wire [`BAE_BEAM_AW-1:0] pfx_wdata;
	wire pfx_we;
	wire beam_take;
	wire [15:0] sr;
	wire [15:0] er;
	wire [15:0] beam_cnt16;
	wire [`BAE_BEAM_AW-1:0] ps;
	wire [`BAE_BEAM_AW-1:0] blk;
	wire [`BAE_BEAM_AW-1:0] span;
	wire [15:0] act;
	wire empty;

	// Map a boundary field to a beam number; symbolic codes pick the scan references
	function [15:0] resolve;
		input [15:0] code;
		input [15:0] fb;
		input [15:0] fc;
		input [15:0] lb;
		input [15:0] lc;
		input [15:0] tm;
		begin
			case (code)
				`BAE_CODE_FB: resolve = fb;
				`BAE_CODE_FC: resolve = fc;
				`BAE_CODE_LB: resolve = lb;
				`BAE_CODE_LC: resolve = lc;
				`BAE_CODE_TM: resolve = tm;
				default: resolve = code;
			endcase
		end
	endfunction

	// Widen a beam count to a field width for threshold compares
	function [15:0] widen;
		input [`BAE_BEAM_AW-1:0] v;
		begin
			widen = {{(16-`BAE_BEAM_AW){1'b0}}, v};
		end
	endfunction

	// Address decode: word index and area number, n at index 99 plus n
	assign widx = paddr[11:2];
	assign area_off = widx - `BAE_AREA_FIRST_IDX;
	assign area_hit = (widx >= `BAE_AREA_FIRST_IDX) && (widx <= `BAE_AREA_LAST_IDX);
	assign access = psel && penable && !pready;

	// Record memory is shared; software only reaches it while no scan is being handled
	assign apb_cfg_go = access && area_hit && (state_q == S_IDLE) && !apb_mem_q;
	assign cfg_addr = (state_q == S_IDLE) ? area_off[`BAE_AREA_AW-1:0] : area_q;
	assign cfg_we = apb_cfg_go && pwrite;
	assign cfg_wdata = {stg3_q, stg2_q, stg1_q, stg0_q};

	// Areas never written read as the reset record, since the memory itself has no reset
	assign cfg_rec = area_init_q[cfg_addr] ? cfg_rd : `BAE_CFG_DEFAULT;

	bae_mem #(
		.W(`BAE_CFG_W),
		.AW(`BAE_AREA_AW)
	) u_cfg_mem (
		.clk(pclk),
		.ce(ce),
		.we(cfg_we),
		.addr(cfg_addr),
		.wdata(cfg_wdata),
		.rdata_q(cfg_rd)
	);

	// Prefix memory: entry n holds the number of blocked beams among beams 1 to n
	assign beam_next = beam_cnt_q + `BAE_BEAM_ONE;
	assign beam_take = (state_q == S_SCAN) && beam_valid && (beam_cnt_q < `BAE_MAX_BEAMS);
	assign pfx_we = beam_take;
	assign pfx_wdata = blk_cnt_q + {{(`BAE_BEAM_AW-1){1'b0}}, beam_blocked};
	assign pfx_addr = (state_q == S_SCAN) ? beam_next :
		(state_q == S_PE) ? e_q[`BAE_BEAM_AW-1:0] : s_q[`BAE_BEAM_AW-1:0] - `BAE_BEAM_ONE;

	bae_mem #(
		.W(`BAE_BEAM_AW),
		.AW(`BAE_BEAM_AW)
	) u_pfx_mem (
		.clk(pclk),
		.ce(ce),
		.we(pfx_we),
		.addr(pfx_addr),
		.wdata(pfx_wdata),
		.rdata_q(pfx_rd)
	);

	// Boundary resolution against this scan's references
	assign sr = resolve(cfg_rec[`BAE_START_LSB +: `BAE_F16_W], first_blocked_beam_q,
		first_clear_beam_q, last_blocked_beam_q, last_clear_beam_q, tmin_q);
	assign er = resolve(cfg_rec[`BAE_END_LSB +: `BAE_F16_W], first_blocked_beam_q,
		first_clear_beam_q, last_blocked_beam_q, last_clear_beam_q, tmin_q);
	assign beam_cnt16 = widen(beam_cnt_q);

	// Active count over [s, e]; an empty or missing range counts nothing
	assign ps = (s_q == `BAE_BEAM_ONE16) ? {`BAE_BEAM_AW{1'b0}} : pfx_rd;
	assign blk = pe_q - ps;
	assign span = e_q[`BAE_BEAM_AW-1:0] - s_q[`BAE_BEAM_AW-1:0] + `BAE_BEAM_ONE;
	assign empty = (s_q > e_q) || (e_q == `BAE_ZERO16);
	assign act = empty ? `BAE_ZERO16 :
		((pol_q == `BAE_POL_LIGHT) ? widen(span - blk) : widen(blk));

	// Scan capture and per-area evaluation sequence
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= S_IDLE;
			area_q <= {`BAE_AREA_AW{1'b0}};
			beam_cnt_q <= {`BAE_BEAM_AW{1'b0}};
			blk_cnt_q <= {`BAE_BEAM_AW{1'b0}};
			first_blocked_beam_q <= `BAE_ZERO16;
			first_clear_beam_q <= `BAE_ZERO16;
			last_blocked_beam_q <= `BAE_ZERO16;
			last_clear_beam_q <= `BAE_ZERO16;
			tmin_q <= `BAE_ZERO16;
			s_q <= `BAE_ZERO16;
			e_q <= `BAE_ZERO16;
			en_q <= 8'h00;
			pol_q <= 8'h00;
			on_q <= `BAE_ZERO16;
			off_q <= `BAE_ZERO16;
			pe_q <= {`BAE_BEAM_AW{1'b0}};
			area_result <= 32'h0000_0000;
			eval_done <= 1'b0;
		end
		else if (ce)
		begin
			eval_done <= 1'b0;
			case (state_q)
				S_IDLE:
				begin
					if (scan_start)
						state_q <= S_SCAN;
				end
				S_SCAN:
				begin
					// References follow the logical order in which beams arrive
					if (beam_take)
					begin
						beam_cnt_q <= beam_next;
						blk_cnt_q <= pfx_wdata;
						if (beam_blocked)
						begin
							if (first_blocked_beam_q == `BAE_ZERO16)
								first_blocked_beam_q <= widen(beam_next);
							last_blocked_beam_q <= widen(beam_next);
						end
						else
						begin
							if (first_clear_beam_q == `BAE_ZERO16)
								first_clear_beam_q <= widen(beam_next);
							last_clear_beam_q <= widen(beam_next);
						end
					end
					if (!scan_start)
					begin
						tmin_q <= target_minimum_beam;
						state_q <= S_CFG;
						area_q <= {`BAE_AREA_AW{1'b0}};
					end
				end
				S_CFG:
					state_q <= S_RES;
				S_RES:
				begin
					// Missing reference resolves to 0; the start then clamps to beam 1
					s_q <= (sr == `BAE_ZERO16) ? `BAE_BEAM_ONE16 : sr;
					e_q <= (er > beam_cnt16) ? beam_cnt16 : er;
					en_q <= cfg_rec[`BAE_EN_LSB +: `BAE_F8_W];
					pol_q <= cfg_rec[`BAE_POL_LSB +: `BAE_F8_W];
					on_q <= cfg_rec[`BAE_ON_LSB +: `BAE_F16_W];
					off_q <= cfg_rec[`BAE_OFF_LSB +: `BAE_F16_W];
					state_q <= S_PE;
				end
				S_PE:
					state_q <= S_PS;
				S_PS:
				begin
					pe_q <= pfx_rd;
					state_q <= S_CNT;
				end
				S_CNT:
				begin
					// Switch-on wins when both thresholds match; between them the bit holds
					if (en_q != `BAE_EN_ON)
						area_result[area_q] <= 1'b0;
					else if (act >= on_q)
						area_result[area_q] <= 1'b1;
					else if (act <= off_q)
						area_result[area_q] <= 1'b0;
					area_q <= area_q + 5'h01;
					if (area_q == `BAE_LAST_AREA)
					begin
						state_q <= S_IDLE;
						eval_done <= 1'b1;
					end
					else
						state_q <= S_CFG;
				end
				default:
					state_q <= S_IDLE;
			endcase
			// Fresh scan clears the capture state
			if (state_q == S_IDLE && scan_start)
			begin
				beam_cnt_q <= {`BAE_BEAM_AW{1'b0}};
				blk_cnt_q <= {`BAE_BEAM_AW{1'b0}};
				first_blocked_beam_q <= `BAE_ZERO16;
				first_clear_beam_q <= `BAE_ZERO16;
				last_blocked_beam_q <= `BAE_ZERO16;
				last_clear_beam_q <= `BAE_ZERO16;
			end
		end
	end

	// APB slave: staging words carry a whole record, area words commit or fetch it
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			apb_mem_q <= 1'b0;
			area_init_q <= 32'h0000_0000;
			stg0_q <= 32'h0000_0000;
			stg1_q <= 32'h0000_0000;
			stg2_q <= 32'h0000_0000;
			stg3_q <= 16'h0000;
		end
		else if (ce)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			if (apb_mem_q)
			begin
				// Record fetched one cycle ago: load the staging words, return the low word
				apb_mem_q <= 1'b0;
				pready <= 1'b1;
				if (!pwrite)
				begin
					stg0_q <= cfg_rec[31:0];
					stg1_q <= cfg_rec[63:32];
					stg2_q <= cfg_rec[95:64];
					stg3_q <= cfg_rec[111:96];
					prdata <= cfg_rec[31:0];
				end
			end
			else if (apb_cfg_go)
			begin
				apb_mem_q <= 1'b1;
				if (pwrite)
					area_init_q[area_off[`BAE_AREA_AW-1:0]] <= 1'b1;
			end
			else if (access && !area_hit)
			begin
				// Plain registers answer after one wait cycle in the access phase
				pready <= 1'b1;
				prdata <= 32'h0000_0000;
				case (widx)
					`BAE_IDX_STG0:
					begin
						if (pwrite)
							stg0_q <= pwdata;
						else
							prdata <= stg0_q;
					end
					`BAE_IDX_STG1:
					begin
						if (pwrite)
							stg1_q <= pwdata;
						else
							prdata <= stg1_q;
					end
					`BAE_IDX_STG2:
					begin
						if (pwrite)
							stg2_q <= pwdata;
						else
							prdata <= stg2_q;
					end
					`BAE_IDX_STG3:
					begin
						if (pwrite)
							stg3_q <= pwdata[15:0];
						else
							prdata <= {16'h0000, stg3_q};
					end
					`BAE_IDX_RESULT:
						prdata <= area_result;
					`BAE_IDX_STATUS:
						prdata <= {13'h0000, state_q, 5'h00, beam_cnt_q};
					`BAE_IDX_REFA:
						prdata <= {first_clear_beam_q, first_blocked_beam_q};
					`BAE_IDX_REFB:
						prdata <= {last_clear_beam_q, last_blocked_beam_q};
					default:
						pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule

//--- bae_properties.sv
// Port checker for the beam area evaluator
`timescale 1ns/1ps
module bae_properties (
	input wire pclk, // Clock
	input wire presetn, // Reset, active low
	input wire ce, // Clock enable
	input wire [11:0] paddr, // APB address
	input wire psel, // APB select
	input wire penable, // APB access
	input wire pready, // APB ready
	input wire pslverr, // APB error
	input wire scan_start, // Frame level
	input wire [31:0] area_result, // Area results
	input wire eval_done // Scan evaluated
);
	// Word index and area window decode
	wire [9:0] idx = paddr[11:2];
	wire area_w = idx >= 10'h064 && idx <= 10'h083;
	// Quiet while frozen, since a low clock enable stretches every answer
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !ce);
	ready_in_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	ready_one_cycle_a: assert property (pready |=> !pready)
		else $error("ready held");
	error_with_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	error_unmapped_a: assert property (pslverr |-> idx > 10'h007 && !area_w)
		else $error("error on mapped word");
	area_wait_a: assert property (pready && area_w |-> $past(penable, 2))
		else $error("area word answered early");
	done_one_cycle_a: assert property (eval_done |=> !eval_done)
		else $error("done held");
	done_timing_a: assert property ($fell(scan_start) |-> ##[155:165] eval_done)
		else $error("evaluation late");
	frame_hold_a: assert property (scan_start |=> $stable(area_result))
		else $error("result moved in frame");
	result_eval_a: assert property ($changed(area_result) |-> ##[0:170] eval_done)
		else $error("result moved outside evaluation");
	cover property (pslverr);
	cover property (eval_done && area_result != 32'h0000_0000);
	cover property (pready && area_w);
endmodule

//--- test_bae_top.sv
// Self-checking bench for the beam area evaluator
`timescale 1ns/1ps
`include "bae_consts.vh"
module test_bae_top;
	logic pclk = 0;
	logic presetn = 0;
	logic ce = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic scan_start = 0;
	logic beam_valid = 0;
	logic beam_blocked = 0;
	logic [15:0] tmb = 0;
	wire [31:0] prdata;
	wire [31:0] area_result;
	wire pready;
	wire pslverr;
	wire eval_done;
	int err_count = 0;
	int cmp_count = 0;
	int seed = 32'hc24e;
	int fb, fc, lb, lc;
	logic [111:0] cfg [32];
	logic [31:0] res = 0;
	logic bl [1:1774];
	logic [31:0] rd;
	logic er;
	// Free-running bench clock
	always #20 pclk = ~pclk;
	bae_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scan_start(scan_start),
		.beam_valid(beam_valid), .beam_blocked(beam_blocked),
		.target_minimum_beam(tmb), .area_result(area_result), .eval_done(eval_done));
	task automatic stop_test;
		if (err_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// One APB transfer; an edge passes first so psel never changes twice in a step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 500);
		if (pready !== 1'b1)
		begin
			err_count++;
			stop_test;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Stage four words then commit; junk above bit 111 must be dropped
	task automatic wrec(input int n, input logic [127:0] v);
		for (int i = 0; i < 4; i++)
			apb(1, 12'(4 * i), v[32 * i +: 32]);
		apb(1, 12'(4 * (99 + n)), 0);
		cfg[n - 1] = v[111:0];
	endtask
	task automatic rrec(input int n);
		apb(0, 12'(4 * (99 + n)), 0);
		chk("rec", rd, cfg[n - 1][31:0]);
		for (int i = 1; i < 4; i++)
		begin
			apb(0, 12'(4 * i), 0);
			chk("rec", rd, 32'(cfg[n - 1] >> (32 * i)));
		end
	endtask
	function automatic int rv(int c);
		case (c)
			65534: return fb;
			65533: return fc;
			65532: return lb;
			65531: return lc;
			65530: return tmb;
			default: return c;
		endcase
	endfunction
	function automatic logic [15:0] bnd(int k);
		if (k % 8 < 5)
			return 16'(65530 + k % 5);
		return 16'(1 + ($random(seed) & 63));
	endfunction
	// One frame, blocked with chance dens/8, then every area against the model
	task automatic scan(input int nb, input int dens);
		int s, e, c, k;
		logic [111:0] r;
		fb = 0;
		fc = 0;
		lb = 0;
		lc = 0;
		@(posedge pclk);
		scan_start <= 1;
		for (int b = 1; b <= nb; b++)
		begin
			bl[b] = ($random(seed) & 7) < dens;
			if (bl[b])
			begin
				if (fb == 0)
					fb = b;
				lb = b;
			end
			else
			begin
				if (fc == 0)
					fc = b;
				lc = b;
			end
			@(posedge pclk);
			beam_valid <= 1;
			beam_blocked <= bl[b];
		end
		@(posedge pclk);
		beam_valid <= 0;
		scan_start <= 0;
		// Some frames freeze the evaluation for a while; results must not suffer
		if (dens % 4 == 2)
		begin
			@(posedge pclk);
			ce <= 0;
			repeat (10) @(posedge pclk);
			ce <= 1;
		end
		k = 0;
		while (eval_done !== 1'b1 && k < 400)
		begin
			@(posedge pclk);
			k++;
		end
		chk("done", {31'h0, eval_done}, 1);
		if (eval_done !== 1'b1)
			stop_test;
		for (int a = 0; a < 32; a++)
		begin
			r = cfg[a];
			s = rv(r[95:80]);
			e = rv(r[79:64]);
			if (s == 0)
				s = 1;
			if (e > nb)
				e = nb;
			c = 0;
			for (int b = s; b <= e; b++)
				c += bl[b] ^ (r[103:96] == 0);
			if (r[111:104] != 1)
				res[a] = 0;
			else if (c >= r[63:48])
				res[a] = 1;
			else if (c <= r[47:32])
				res[a] = 0;
			chk("area", {31'h0, area_result[a]}, {31'h0, res[a]});
		end
		apb(0, 12'h018, 0);
		chk("refa", rd, {fc[15:0], fb[15:0]});
		apb(0, 12'h01c, 0);
		chk("refb", rd, {lc[15:0], lb[15:0]});
		apb(0, 12'h010, 0);
		chk("result", rd, res);
	endtask
	// Main sequence: defaults, a refused word, then five frames
	initial
	begin
		logic [127:0] v;
		for (int a = 0; a < 32; a++)
			cfg[a] = `BAE_CFG_DEFAULT;
		repeat (8) @(posedge pclk);
		presetn <= 1;
		rrec(32);
		apb(0, 12'h020, 0);
		chk("err", {31'h0, er}, 1);
		for (int s = 0; s < 5; s++)
		begin
			for (int a = 1; a <= 32; a++)
			begin
				for (int i = 0; i < 4; i++)
					v[32 * i +: 32] = $random(seed);
				v[111:104] = (a % 5 == 0) ? 8'h02 : 8'(a % 4 != 1);
				v[103:96] = 8'((a + s) % 2);
				v[95:80] = bnd(a + s);
				v[79:64] = bnd(a + 3 * s + 1);
				v[63:48] = 16'($random(seed) & 15);
				v[47:32] = 16'($random(seed) & 15);
				v[31:16] = 16'($unsigned($random(seed)) % 1775);
				v[15:0] = 16'($unsigned($random(seed)) % 1775);
				wrec(a, v);
			end
			rrec(s + 3);
			tmb <= 16'($unsigned($random(seed)) % 70);
			scan(20 + 8 * s, 2 * s);
		end
		// Mid-run reset returns every record and result to its reset value
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		for (int a = 0; a < 32; a++)
			cfg[a] = `BAE_CFG_DEFAULT;
		res = 0;
		chk("reset", area_result, 0);
		rrec(1);
		apb(0, 12'h018, 0);
		chk("refa", rd, 0);
		stop_test;
	end
endmodule
bind bae_top bae_properties prop_i (.pclk(pclk), .presetn(presetn), .ce(ce),
	.paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.scan_start(scan_start), .area_result(area_result), .eval_done(eval_done));
